// File: inc/usc_pkg.sv
// Purpose: Shared constants and types of the serial shift unit control.
// Assumes: AHB-Lite word access, 8-bit registers in the low byte lanes.
// Notes: Offsets are byte addresses within the unit's window.
package usc_pkg;
  // Register byte offsets.
  localparam logic [7:0] USC_CTRL_OFS = 8'h00;
  localparam logic [7:0] USC_STAT_OFS = 8'h04;
  localparam logic [7:0] USC_DATA_OFS = 8'h08;
  localparam logic [7:0] USC_PORT_OFS = 8'h0c;
  // Control register fields.
  localparam int USC_C_SIE = 7;
  localparam int USC_C_OIE = 6;
  localparam int USC_C_WM = 4;
  localparam int USC_C_CS = 2;
  localparam int USC_C_CLK = 1;
  localparam int USC_C_TC = 0;
  // Status register fields.
  localparam int USC_S_SIF = 7;
  localparam int USC_S_OIF = 6;
  // Pin input read-back positions in the port register.
  localparam int USC_P_SDA_IN = 6;
  localparam int USC_P_SCL_IN = 7;
  // Wire modes.
  localparam logic [1:0] USC_WM_OFF = 2'h0;
  localparam logic [1:0] USC_WM_THREE = 2'h1;
  localparam logic [1:0] USC_WM_TWO = 2'h2;
  localparam logic [1:0] USC_WM_TWO_HOLD = 2'h3;
  // Clock sources.
  localparam logic [1:0] USC_CS_SOFT = 2'h0;
  localparam logic [1:0] USC_CS_TMR = 2'h1;
  // Bus and counter constants.
  localparam logic [2:0] USC_HSIZE_WORD = 3'h2;
  localparam logic [1:0] USC_HRESP_OKAY = 2'h0;
  localparam logic [3:0] USC_CNT_MAX = 4'hf;
  localparam logic [3:0] USC_CNT_ONE = 4'h1;
  localparam logic [7:0] USC_BYTE_ZERO = 8'h00;
  localparam logic [23:0] USC_PAD_ZERO = 24'h000000;
  // One drive of a pin: level and output enable.
  typedef struct packed {
    logic o;
    logic oe;
  } usc_pin_type;
  // Port bits and directions, in register bit order 5..0.
  typedef struct packed {
    logic scl_dir;
    logic scl_port;
    logic sda_dir;
    logic sda_port;
    logic do_dir;
    logic do_port;
  } usc_port_type;
  // Captured address phase.
  typedef struct packed {
    logic [7:0] ofs;
    logic wr;
    logic rd;
  } usc_aphase_type;
endpackage : usc_pkg

// File: core/usc_serial_ctrl.sv
// Purpose: Control logic of a universal serial shift unit on AHB-Lite.
// Assumes: Pins arrive asynchronous; timer match is a same-clock pulse.
// Notes: Pin drives and interrupt requests are registered outputs.
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module usc_serial_ctrl
  import usc_pkg::*;
#(
  parameter int SYNC_STAGES = 3
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic tmr_match,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic sda_pullup,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  output logic scl_pullup,
  output logic do_o,
  output logic do_oe,
  output logic do_pullup,
  output logic ovf_irq,
  output logic start_irq
);

  // True for both two-wire modes.
  function automatic logic two_wire(input logic [1:0] wm);
    two_wire = wm[1];
  endfunction : two_wire

  usc_aphase_type aph_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic sie_q;
  logic oie_q;
  logic [1:0] wm_q;
  logic [1:0] cs_q;
  logic sel_q;
  usc_port_type port_q;
  logic [7:0] shreg_q;
  logic [7:0] shreg_d;
  logic latch_q;
  logic [3:0] cnt_q;
  logic oif_q;
  logic oif_d;
  logic sif_q;
  logic sif_d;
  usc_pin_type sda_q;
  usc_pin_type scl_q;
  usc_pin_type do_q;
  usc_pin_type sda_d;
  usc_pin_type scl_d;
  usc_pin_type do_d;
  logic sda_pu_q;
  logic scl_pu_q;
  logic do_pu_q;
  logic ovf_irq_q;
  logic start_irq_q;
  logic [1:0] pin_in;
  logic [1:0] filt;
  logic [1:0] rise;
  logic [1:0] fall;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_port;
  logic soft_strobe;
  logic tc_strobe;
  logic tmr_tick;
  logic ext_shift;
  logic shift_tick;
  logic cnt_tick;
  logic ovf_set;
  logic start_det;
  logic latch_edge;
  logic [7:0] rd_byte;

  // Read data and ready come straight from their registers; the response is fixed at OKAY.
  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  assign hresp = USC_HRESP_OKAY;

  // Address phase capture; a read costs one wait state.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_q <= '0;
      ready_q <= 1'b1;
      rdata_q <= '0;
    end
    else if (ce)
    begin
      if (aph_q.rd)
      begin
        rdata_q <= {USC_PAD_ZERO, rd_byte};
        ready_q <= 1'b1;
        aph_q <= '0;
      end
      else if (hready)
      begin
        aph_q.ofs <= haddr[7:0];
        aph_q.wr <= hsel & htrans[1] & hwrite &
                    (hsize == USC_HSIZE_WORD);
        aph_q.rd <= hsel & htrans[1] & ~hwrite;
        ready_q <= ~(hsel & htrans[1] & ~hwrite);
      end
    end
  end

  // Write strobes of the data phase.
  assign wr_ctrl = aph_q.wr && (aph_q.ofs == USC_CTRL_OFS);
  assign wr_stat = aph_q.wr && (aph_q.ofs == USC_STAT_OFS);
  assign wr_data = aph_q.wr && (aph_q.ofs == USC_DATA_OFS);
  assign wr_port = aph_q.wr && (aph_q.ofs == USC_PORT_OFS);

  // Read mux; unmapped offsets read as zero.
  always_comb
  begin
    rd_byte = USC_BYTE_ZERO;
    case (aph_q.ofs)
      USC_CTRL_OFS:
        rd_byte = {sie_q, oie_q, wm_q, cs_q, 1'b0, 1'b0};
      USC_STAT_OFS:
        rd_byte = {sif_q, oif_q, 2'b00, cnt_q};
      USC_DATA_OFS:
        rd_byte = shreg_q;
      USC_PORT_OFS:
        rd_byte = {filt[1], filt[0], port_q};
      default:
        rd_byte = USC_BYTE_ZERO;
    endcase
  end

  // Pin inputs: three flops, a change counts when the last two agree.
  assign pin_in = {scl_i, sda_i};
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_sync
      logic [SYNC_STAGES-1:0] chain_q;
      logic filt_q;
      logic agree;
      // Synchroniser chain; its first stage feeds only the second.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          chain_q <= '0;
        else if (ce)
          chain_q <= {chain_q[SYNC_STAGES-2:0], pin_in[g]};
      end
      assign agree = chain_q[SYNC_STAGES-1] == chain_q[SYNC_STAGES-2];
      // Filtered level, held until the last two stages agree.
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          filt_q <= 1'b0;
        else if (ce && agree)
          filt_q <= chain_q[SYNC_STAGES-1];
      end
      assign filt[g] = filt_q;
      assign rise[g] = agree & chain_q[SYNC_STAGES-1] & ~filt_q;
      assign fall[g] = agree & ~chain_q[SYNC_STAGES-1] & filt_q;
    end
  endgenerate

  // Clock events; strobes use the value being written.
  assign soft_strobe = wr_ctrl && hwdata[USC_C_CLK] &&
    (hwdata[USC_C_CS+1:USC_C_CS] == USC_CS_SOFT);
  assign tc_strobe = wr_ctrl && hwdata[USC_C_TC];
  assign tmr_tick = (cs_q == USC_CS_TMR) && tmr_match;
  assign ext_shift = cs_q[1] & (cs_q[0] ? fall[1] : rise[1]);
  assign shift_tick = soft_strobe | tmr_tick | ext_shift;
  // Counter: strobe, timer, both external edges, or toggle.
  always_comb
  begin
    cnt_tick = soft_strobe | tmr_tick;
    if (wr_ctrl && hwdata[USC_C_CS+1])
      cnt_tick = hwdata[USC_C_CLK] ? tc_strobe : 1'b0;
    else if (cs_q[1])
      cnt_tick = soft_strobe | (~sel_q & (rise[1] | fall[1]));
  end

  // Control register; strobe bits read as zero, but the clock bit is kept as sel_q for external sources.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sie_q <= 1'b0;
      oie_q <= 1'b0;
      wm_q <= USC_WM_OFF;
      cs_q <= USC_CS_SOFT;
      sel_q <= 1'b0;
    end
    else if (ce && wr_ctrl)
    begin
      sie_q <= hwdata[USC_C_SIE];
      oie_q <= hwdata[USC_C_OIE];
      wm_q <= hwdata[USC_C_WM+1:USC_C_WM];
      cs_q <= hwdata[USC_C_CS+1:USC_C_CS];
      sel_q <= hwdata[USC_C_CLK] & hwdata[USC_C_CS+1];
    end
  end

  // Port bits; a toggle write inverts the clock port bit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_q <= '0;
    else if (ce)
    begin
      if (wr_port)
        port_q <= hwdata[5:0];
      else if (tc_strobe)
        port_q.scl_port <= ~port_q.scl_port;
    end
  end

  // Shift register; a bus write wins over a shift.
  always_comb
  begin
    shreg_d = shreg_q;
    if (wr_data)
      shreg_d = hwdata[7:0];
    else if (shift_tick)
      shreg_d = {shreg_q[6:0], filt[0]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shreg_q <= '0;
    else if (ce)
      shreg_q <= shreg_d;
  end

  // Output latch: transparent for internal clocks, else opposite edge.
  assign latch_edge = cs_q[0] ? rise[1] : fall[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      latch_q <= 1'b0;
    else if (ce)
    begin
      if (!cs_q[1] || wr_data || latch_edge)
        latch_q <= shreg_d[7];
    end
  end

  // Four-bit counter; a bus write wins over a count.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= '0;
    else if (ce)
    begin
      if (wr_stat)
        cnt_q <= hwdata[3:0];
      else if (cnt_tick)
        cnt_q <= cnt_q + USC_CNT_ONE;
    end
  end

  // Flags: a start set wins over a write-one clear; a status write blocks any overflow set.
  assign ovf_set = cnt_tick && !wr_stat && (cnt_q == USC_CNT_MAX);
  assign start_det = two_wire(wm_q) & filt[1] & ~fall[1] & fall[0];
  assign oif_d = ovf_set |
    (oif_q & ~(wr_stat & hwdata[USC_S_OIF]));
  assign sif_d = start_det |
    (sif_q & ~(wr_stat & hwdata[USC_S_SIF]));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      oif_q <= 1'b0;
      sif_q <= 1'b0;
    end
    else if (ce)
    begin
      oif_q <= oif_d;
      sif_q <= sif_d;
    end
  end

  // Pin drive and pull-up selection by wire mode.
  always_comb
  begin
    sda_d = '{o: port_q.sda_port, oe: port_q.sda_dir};
    scl_d = '{o: port_q.scl_port, oe: port_q.scl_dir};
    do_d = '{o: port_q.do_port, oe: port_q.do_dir};
    if (wm_q == USC_WM_THREE)
      do_d.o = latch_q;
    if (two_wire(wm_q))
    begin
      sda_d.o = 1'b0;
      sda_d.oe = port_q.sda_dir &
        (~latch_q | ~port_q.sda_port);
      scl_d.o = 1'b0;
      scl_d.oe = port_q.scl_dir &
        (~port_q.scl_port | sif_q |
        ((wm_q == USC_WM_TWO_HOLD) & oif_q));
    end
  end

  // Registered pin outputs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sda_q <= '0;
      scl_q <= '0;
      do_q <= '0;
      sda_pu_q <= 1'b0;
      scl_pu_q <= 1'b0;
      do_pu_q <= 1'b0;
    end
    else if (ce)
    begin
      sda_q <= sda_d;
      scl_q <= scl_d;
      do_q <= do_d;
      sda_pu_q <= ~port_q.sda_dir & port_q.sda_port &
        ~two_wire(wm_q);
      scl_pu_q <= ~port_q.scl_dir & port_q.scl_port &
        ~two_wire(wm_q);
      do_pu_q <= ~port_q.do_dir & port_q.do_port;
    end
  end

  assign sda_o = sda_q.o;
  assign sda_oe = sda_q.oe;
  assign scl_o = scl_q.o;
  assign scl_oe = scl_q.oe;
  assign do_o = do_q.o;
  assign do_oe = do_q.oe;
  assign sda_pullup = sda_pu_q;
  assign scl_pullup = scl_pu_q;
  assign do_pullup = do_pu_q;

  // Request levels follow flag and enable one cycle later, so a pending flag asks on the cycle after its enable is set.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf_irq_q <= 1'b0;
      start_irq_q <= 1'b0;
    end
    else if (ce)
    begin
      ovf_irq_q <= oie_q & oif_q;
      start_irq_q <= sie_q & sif_q;
    end
  end

  assign ovf_irq = ovf_irq_q;
  assign start_irq = start_irq_q;

endmodule : usc_serial_ctrl
`default_nettype wire

// File: verification/usc_checker.sv
// Purpose: Port assertions for the serial unit control.
// Assumes: One AHB-Lite master issuing whole-word transfers.
// Notes: Control bits are shadowed from observed writes.
`timescale 1ns/1ps
`default_nettype none
module usc_checker
  import usc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic sda_pullup,
  input wire logic scl_pullup,
  input wire logic ovf_irq,
  input wire logic start_irq
);
  logic wr_q;
  logic [7:0] ofs_q;
  logic [7:0] ctl_q;
  logic ctl_wr, stat_wr, ovf_clr, st_clr;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Remembers the address phase of each accepted write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      ofs_q <= USC_BYTE_ZERO;
    end
    else if (hready)
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      ofs_q <= haddr[7:0];
    end
  end
  // Shadow copy of the control byte.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctl_q <= USC_BYTE_ZERO;
    else if (ctl_wr)
      ctl_q <= hwdata[7:0];
  end
  // Writes that may take an interrupt request away.
  assign ctl_wr = wr_q && ofs_q == USC_CTRL_OFS;
  assign stat_wr = wr_q && ofs_q == USC_STAT_OFS;
  assign ovf_clr = stat_wr && hwdata[USC_S_OIF] ||
    ctl_wr && !hwdata[USC_C_OIE];
  assign st_clr = stat_wr && hwdata[USC_S_SIF] ||
    ctl_wr && !hwdata[USC_C_SIE];
  a_read_wait: assert property (hready && hsel && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  a_write_nowait: assert property (hready && hsel && htrans[1] && hwrite
    |=> hreadyout) else $error("write stalled");
  a_ovf_irq_en: assert property (ovf_irq |->
    ctl_q[USC_C_OIE] || $past(ctl_q[USC_C_OIE]))
    else $error("overflow request while disabled");
  a_start_irq_en: assert property (start_irq |->
    ctl_q[USC_C_SIE] || $past(ctl_q[USC_C_SIE]))
    else $error("start request while disabled");
  a_ovf_clear: assert property ($fell(ovf_irq) |-> $past(ovf_clr, 2))
    else $error("overflow request dropped by itself");
  a_start_clear: assert property ($fell(start_irq) |-> $past(st_clr, 2))
    else $error("start request dropped by itself");
  a_two_wire_low: assert property (ctl_q[USC_C_WM+1] &&
    $past(ctl_q[USC_C_WM+1]) |-> !sda_o && !scl_o)
    else $error("two-wire driver drives high");
  a_pullup_off: assert property (ctl_q[USC_C_WM+1] &&
    $past(ctl_q[USC_C_WM+1]) |-> !sda_pullup && !scl_pullup)
    else $error("pull-up on in two-wire mode");
endmodule : usc_checker
bind usc_serial_ctrl usc_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .sda_o(sda_o), .scl_o(scl_o), .sda_pullup(sda_pullup),
  .scl_pullup(scl_pullup), .ovf_irq(ovf_irq), .start_irq(start_irq));
`default_nettype wire

// File: verification/usc_peer_model.sv
// Purpose: Remote two-wire bus party with a bus pull-up.
// Assumes: Clock stands high outside frames.
// Notes: Released lines read high through the pull-up.
`timescale 1ns/1ps
`default_nettype none
module usc_peer_model
#(
  parameter int HALF = 80
)
(
  input wire logic run,
  input wire logic start,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  output logic sda_line,
  output logic scl_line
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // Wired-and of both parties on each line.
  assign sda_line = !(dev_sda_oe && !dev_sda_o) && !sda_low;
  assign scl_line = !(dev_scl_oe && !dev_scl_o) && !scl_low;
  // Clock pulses are made only while a frame runs.
  always
  begin
    wait (run);
    scl_low = 1'b1;
    #(HALF);
    scl_low = 1'b0;
    #(HALF);
  end
  // Data falls while the clock is high, which is a start condition.
  always @(start)
    sda_low = start;
endmodule : usc_peer_model
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Register and pin tests of the serial unit control.
// Assumes: Word transfers only; link pulses at 160 ns.
// Notes: Pin checks wait a few cycles for registered outputs.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import usc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, tmr_match, run, start;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic hreadyout, sda_line, scl_line, sda_o, sda_oe, sda_pullup;
  logic scl_o, scl_oe, scl_pullup, do_o, do_oe, do_pullup;
  logic ovf_irq, start_irq;
  int err_count, n_compared;
  usc_serial_ctrl uut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tmr_match(tmr_match), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .sda_pullup(sda_pullup), .scl_i(scl_line),
    .scl_o(scl_o), .scl_oe(scl_oe), .scl_pullup(scl_pullup),
    .do_o(do_o), .do_oe(do_oe), .do_pullup(do_pullup),
    .ovf_irq(ovf_irq), .start_irq(start_irq));
  usc_peer_model u_peer (.run(run), .start(start), .dev_sda_o(sda_o),
    .dev_sda_oe(sda_oe), .dev_scl_o(scl_o), .dev_scl_oe(scl_oe),
    .sda_line(sda_line), .scl_line(scl_line));
  // Free-running system clock.
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic summarize;
    if (err_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : pin
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    chk({31'h0, n >= 50}, 32'h0);
    if (n >= 50)
      summarize();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask : settle
  task automatic pulses(input int n);
    @(posedge hclk);
    run <= 1'b1;
    repeat (n * 16 - 1) @(posedge hclk);
    run <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : pulses
  task automatic tmr(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      tmr_match <= 1'b1;
      @(posedge hclk);
      tmr_match <= 1'b0;
    end
  endtask : tmr
  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_count++;
    $display("ERROR %0t: run timed out", $time);
    summarize();
  end
  // Main sequence of register and pin scenarios.
  initial
  begin
    {hresetn, hwrite, tmr_match, run, start} = 5'h0;
    {haddr, hwdata, htrans, err_count, n_compared} = 0;
    hsel = 1'b1;
    hsize = USC_HSIZE_WORD;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(USC_CTRL_OFS, 32'h0);
    rdc(8'h10, 32'h0);
    wr(USC_DATA_OFS, 32'h0);
    wr(USC_CTRL_OFS, 32'h08);
    pulses(4);
    rdc(USC_STAT_OFS, 32'h08);
    rdc(USC_DATA_OFS, 32'h0f);
    wr(USC_CTRL_OFS, 32'h0b);
    rdc(USC_STAT_OFS, 32'h09);
    rdc(USC_PORT_OFS, 32'hd0);
    rdc(USC_CTRL_OFS, 32'h08);
    pulses(1);
    rdc(USC_STAT_OFS, 32'h09);
    wr(USC_CTRL_OFS, 32'h0c);
    pulses(1);
    rdc(USC_STAT_OFS, 32'h0b);
    rdc(USC_DATA_OFS, 32'h3f);
    wr(USC_STAT_OFS, 32'h0f);
    wr(USC_CTRL_OFS, 32'h02);
    rdc(USC_STAT_OFS, 32'h40);
    rdc(USC_DATA_OFS, 32'h7f);
    rdc(USC_CTRL_OFS, 32'h00);
    pin(ovf_irq, 1'b0);
    wr(USC_CTRL_OFS, 32'h40);
    settle();
    pin(ovf_irq, 1'b1);
    wr(USC_STAT_OFS, 32'h40);
    settle();
    pin(ovf_irq, 1'b0);
    tmr(2);
    rdc(USC_STAT_OFS, 32'h00);
    wr(USC_CTRL_OFS, 32'h04);
    tmr(3);
    rdc(USC_STAT_OFS, 32'h03);
    wr(USC_CTRL_OFS, 32'h00);
    wr(USC_PORT_OFS, 32'h14);
    settle();
    pin(sda_pullup, 1'b1);
    pin(scl_oe, 1'b0);
    wr(USC_DATA_OFS, 32'h00);
    wr(USC_CTRL_OFS, 32'ha0);
    settle();
    pin(sda_pullup, 1'b0);
    pin(sda_oe, 1'b0);
    wr(USC_PORT_OFS, 32'h3c);
    settle();
    pin(sda_oe, 1'b1);
    pin(scl_oe, 1'b0);
    wr(USC_DATA_OFS, 32'h80);
    settle();
    pin(sda_oe, 1'b0);
    wr(USC_PORT_OFS, 32'h28);
    settle();
    pin(sda_oe, 1'b1);
    pin(scl_oe, 1'b1);
    wr(USC_PORT_OFS, 32'h3c);
    wr(USC_STAT_OFS, 32'h80);
    settle();
    pin(scl_oe, 1'b0);
    start <= 1'b1;
    repeat (12) @(posedge hclk);
    pin(scl_oe, 1'b1);
    pin(start_irq, 1'b1);
    wr(USC_STAT_OFS, 32'h80);
    settle();
    pin(scl_oe, 1'b0);
    start <= 1'b0;
    wr(USC_STAT_OFS, 32'h0f);
    wr(USC_CTRL_OFS, 32'h32);
    settle();
    pin(scl_oe, 1'b1);
    wr(USC_STAT_OFS, 32'h40);
    settle();
    pin(scl_oe, 1'b0);
    wr(USC_CTRL_OFS, 32'h10);
    wr(USC_PORT_OFS, 32'h03);
    settle();
    pin(do_o, 1'b0);
    pin(do_oe, 1'b1);
    pin(do_pullup, 1'b0);
    wr(USC_DATA_OFS, 32'h80);
    settle();
    pin(do_o, 1'b1);
    summarize();
  end
endmodule : testbench
`default_nettype wire
